/* verilog/interlaken_lane_pcs.sv */
// Per-lane 64B/67B framing PCS with metaframe, scrambler and CRC
`timescale 1ns/1ps
module interlaken_lane_pcs import pcs_pkg::*; #(
	parameter logic [57:0] SCR_SEED = SCR_SEED_RST
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire fab_word_type tx_word,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [66:0] tx_line,
	input wire logic [66:0] rx_line,
	output fab_word_type rx_word,
	output logic rx_valid,
	input wire logic rx_accept,
	output logic rx_ready,
	output logic rx_word_lock,
	output logic rx_frame_lock,
	output logic rx_crc_err
);
	typedef struct packed {
		logic [12:0] tx_pos;
		logic [57:0] tx_lfsr;
		logic [31:0] tx_crc;
		logic signed [9:0] tx_rd;
		logic [66:0] tx_line;
		logic tx_ready;
		logic [66:0] rx_prev;
		logic [6:0] rx_off;
		blk_state_type blk_st;
		logic [6:0] b_good;
		logic [5:0] b_win;
		logic [4:0] b_bad;
		frm_state_type frm_st;
		logic [12:0] rx_pos;
		logic [2:0] f_cnt;
		logic [2:0] f_bad;
		logic mf_bad;
		logic [57:0] rx_lfsr;
		logic [31:0] rx_crc;
		fab_word_type rx_word;
		logic rx_valid;
		logic rx_ready;
		logic word_lock;
		logic frame_lock;
		logic crc_err;
		pcs_ev_type ev;
	} pcs_st_type;
	pcs_st_type st_r;
	pcs_st_type st_nxt;
	logic [12:0] mf_len;
	logic [12:0] last;
	logic [12:0] t_np;
	logic [1:0] t_hdr;
	logic [63:0] t_pl;
	logic [63:0] t_sp;
	logic [57:0] t_lf;
	logic t_ex;
	logic t_inv;
	logic signed [9:0] t_d0;
	logic [133:0] r_win;
	logic [66:0] r_w;
	logic r_hv;
	logic r_ctl;
	logic r_sync;
	logic r_scr;
	logic r_bad;
	logic [63:0] r_pl;
	logic [63:0] r_dp;
	logic [63:0] r_d;
	logic [57:0] r_lf;
	logic [57:0] r_lf_ss;
	logic [63:0] r_unused;
	logic [4:0] r_nbad;
	logic [31:0] r_base;
	// Ones in a 64-bit word
	function automatic logic [6:0] pop64(input logic [63:0] d);
		logic [6:0] n;
		n = 7'h0;
		for (int i = 0; i < 64; i++)
			n = n + {6'h0, d[i]};
		return n;
	endfunction
	// Register slave; holds the metaframe length and error flags
	pcs_axil_regs u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.word_lock(st_r.word_lock),
		.frame_lock(st_r.frame_lock),
		.ev(st_r.ev),
		.mf_len(mf_len)
	);
	// One length serves both directions of the lane
	assign last = mf_len - 13'h0001;
	// Transmit: frame generator, CRC, scrambler, disparity
	always_comb
	begin
		st_nxt = st_r;
		t_hdr = HDR_CTRL;
		t_pl = SKIP_WORD;
		t_ex = 1'b0;
		// Word choice by metaframe position
		if (st_r.tx_pos == POS_SYNC)
		begin
			t_pl = SYNC_WORD;
			t_ex = 1'b1;
		end
		else if (st_r.tx_pos == POS_SCR)
		begin
			t_pl = {SCR_TYPE, st_r.tx_lfsr};
			t_ex = 1'b1;
		end
		else if (st_r.tx_pos == POS_SKIP)
			t_pl = SKIP_WORD;
		else if (st_r.tx_pos >= last)
			t_pl = {DIAG_TYPE, st_r.tx_crc};
		else if (tx_valid && st_r.tx_ready)
		begin
			// Fabric flag picks control or data header
			t_hdr = tx_word.ctl ? HDR_CTRL : HDR_DATA;
			t_pl = tx_word.data;
		end
		else
			t_pl = SKIP_WORD; // No word offered: fill with skip
		// CRC restarts at the sync word, covers all but diagnostic
		st_nxt.tx_crc = crc_step((st_r.tx_pos == POS_SYNC) ? CRC_INIT :
			st_r.tx_crc, t_pl);
		{t_lf, t_sp} = scr_step(st_r.tx_lfsr, t_pl);
		st_nxt.tx_lfsr = t_lf;
		if (t_ex)
			t_sp = t_pl;
		// Header holds one set bit, so word disparity is 2*ones-65
		t_d0 = $signed({2'h0, pop64(t_sp), 1'b0}) - 10'sd65;
		// Invert when the word pushes further the same way
		t_inv = (st_r.tx_rd[9] == t_d0[9]);
		st_nxt.tx_rd = t_inv ? st_r.tx_rd - t_d0 : st_r.tx_rd + t_d0;
		// Inversion flag, header, payload
		st_nxt.tx_line = {t_inv, t_hdr, t_inv ? ~t_sp : t_sp};
		t_np = (st_r.tx_pos >= last) ? POS_SYNC : st_r.tx_pos + 13'h0001;
		st_nxt.tx_pos = t_np;
		// Ready only in payload slots of the coming word
		st_nxt.tx_ready = (t_np > POS_SKIP) && (t_np < last);
		// Receive: word alignment over two consecutive line words
		r_win = {rx_line, st_r.rx_prev};
		r_w = r_win[st_r.rx_off +: 67];
		st_nxt.rx_prev = rx_line;
		r_hv = r_w[65] ^ r_w[64];
		r_nbad = st_r.b_bad + {4'h0, !r_hv};
		case (st_r.blk_st)
			B_SEARCH:
			begin
				if (r_hv)
				begin
					st_nxt.b_good = st_r.b_good + 7'h01;
					if (st_r.b_good == BLK_GOOD_LAST)
					begin
						st_nxt.blk_st = B_LOCK;
						st_nxt.b_win = 6'h00;
						st_nxt.b_bad = 5'h00;
						st_nxt.word_lock = 1'b1;
					end
				end
				else
				begin
					// Bad header: slip one bit and count afresh
					st_nxt.b_good = 7'h00;
					st_nxt.rx_off = (st_r.rx_off == OFF_LAST) ? 7'h00 :
						st_r.rx_off + 7'h01;
				end
			end
			B_LOCK:
			begin
				st_nxt.b_win = st_r.b_win + 6'h01;
				st_nxt.b_bad = r_nbad;
				if (r_nbad >= BLK_BAD_MAX)
				begin
					st_nxt.blk_st = B_SEARCH;
					st_nxt.b_good = 7'h00;
					st_nxt.word_lock = 1'b0;
					st_nxt.rx_off = (st_r.rx_off == OFF_LAST) ? 7'h00 :
						st_r.rx_off + 7'h01;
				end
				else if (st_r.b_win == BLK_WIN_LAST)
					st_nxt.b_bad = 5'h00;
			end
			default:
				st_nxt.blk_st = B_SEARCH;
		endcase
		// Undo inversion, then classify the word
		r_pl = r_w[66] ? ~r_w[63:0] : r_w[63:0];
		r_ctl = (r_w[65:64] == HDR_CTRL);
		r_sync = r_ctl && (r_pl == SYNC_WORD);
		r_scr = r_ctl && (r_pl[63:58] == SCR_TYPE);
		{r_lf, r_dp} = scr_step(st_r.rx_lfsr, r_pl);
		{r_lf_ss, r_unused} = scr_step(r_pl[57:0], r_pl);
		r_d = (r_sync || r_scr) ? r_pl : r_dp;
		// State word reloads the descrambler
		st_nxt.rx_lfsr = r_scr ? r_lf_ss : r_lf;
		r_base = (st_r.rx_pos == POS_SYNC || st_r.frm_st == F_SEARCH) ?
			CRC_INIT : st_r.rx_crc;
		st_nxt.rx_crc = crc_step(r_base, r_d);
		st_nxt.rx_pos = (st_r.rx_pos >= last) ? POS_SYNC :
			st_r.rx_pos + 13'h0001;
		st_nxt.ev = '0;
		st_nxt.crc_err = 1'b0;
		r_bad = 1'b0;
		// Metaframe synchronizer
		case (st_r.frm_st)
			F_SEARCH:
			begin
				if (st_r.word_lock && r_sync)
				begin
					st_nxt.frm_st = F_VERIFY;
					st_nxt.rx_pos = POS_SCR;
					st_nxt.f_cnt = 3'h1;
				end
			end
			F_VERIFY:
			begin
				if (st_r.rx_pos == POS_SYNC)
				begin
					if (!r_sync)
						st_nxt.frm_st = F_SEARCH;
					else if (st_r.f_cnt == FRM_LOCK_LAST)
					begin
						st_nxt.frm_st = F_LOCK;
						st_nxt.frame_lock = 1'b1;
						st_nxt.f_bad = 3'h0;
						st_nxt.mf_bad = 1'b0;
					end
					else
						st_nxt.f_cnt = st_r.f_cnt + 3'h1;
				end
			end
			F_LOCK:
			begin
				// Check sync and state words of each metaframe
				if (st_r.rx_pos == POS_SYNC && !r_sync)
				begin
					r_bad = 1'b1;
					st_nxt.ev.sync = 1'b1;
				end
				if (st_r.rx_pos == POS_SCR &&
					(!r_scr || r_pl[57:0] != st_r.rx_lfsr))
				begin
					r_bad = 1'b1;
					st_nxt.ev.scr = 1'b1;
				end
				st_nxt.mf_bad = st_r.mf_bad | r_bad;
				if (st_r.rx_pos >= last)
				begin
					// Diagnostic word carries the frame CRC
					if (!r_ctl || r_d[31:0] != st_r.rx_crc)
					begin
						st_nxt.crc_err = 1'b1;
						st_nxt.ev.crc = 1'b1;
					end
					st_nxt.mf_bad = 1'b0;
					if (!st_r.mf_bad)
						st_nxt.f_bad = 3'h0;
					else if (st_r.f_bad == FRM_BAD_LAST)
					begin
						st_nxt.frm_st = F_SEARCH;
						st_nxt.frame_lock = 1'b0;
					end
					else
						st_nxt.f_bad = st_r.f_bad + 3'h1;
				end
			end
			default:
				st_nxt.frm_st = F_SEARCH;
		endcase
		// Word lock loss also ends frame lock
		if (!st_nxt.word_lock)
		begin
			st_nxt.frm_st = F_SEARCH;
			st_nxt.frame_lock = 1'b0;
		end
		// Every aligned word goes out, control words included
		st_nxt.rx_word.ctl = r_ctl;
		st_nxt.rx_word.data = r_d;
		st_nxt.rx_valid = st_r.word_lock;
		st_nxt.rx_ready = st_nxt.word_lock && st_nxt.frame_lock;
		// No buffer here: a refused word is lost and flagged
		st_nxt.ev.ovf = st_r.rx_valid && !rx_accept;
	end
	// State register; seed loads at every reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= '0;
			st_r.tx_lfsr <= SCR_SEED;
			st_r.tx_crc <= CRC_INIT;
			st_r.rx_lfsr <= SCR_SEED;
			st_r.rx_crc <= CRC_INIT;
			st_r.blk_st <= B_SEARCH;
			st_r.frm_st <= F_SEARCH;
		end
		else
			st_r <= st_nxt;
	end
	// Outputs straight from the state register
	assign tx_ready = st_r.tx_ready;
	assign tx_line = st_r.tx_line;
	assign rx_word = st_r.rx_word;
	assign rx_valid = st_r.rx_valid;
	assign rx_ready = st_r.rx_ready;
	assign rx_word_lock = st_r.word_lock;
	assign rx_frame_lock = st_r.frame_lock;
	assign rx_crc_err = st_r.crc_err;
endmodule // interlaken_lane_pcs

/* verilog/pcs_pkg.sv */
// Shared constants, types and coding functions of the lane PCS
package pcs_pkg;
	// Line word header codes
	localparam logic [1:0] HDR_DATA = 2'h1;
	localparam logic [1:0] HDR_CTRL = 2'h2;
	// Metaframe length and fixed word positions
	localparam logic [12:0] MF_LEN_MIN = 13'h0005;
	localparam logic [12:0] MF_LEN_RST = 13'h0800;
	localparam logic [12:0] POS_SYNC = 13'h0000;
	localparam logic [12:0] POS_SCR = 13'h0001;
	localparam logic [12:0] POS_SKIP = 13'h0002;
	// Block lock counts
	localparam logic [6:0] BLK_GOOD_LAST = 7'h3f;
	localparam logic [5:0] BLK_WIN_LAST = 6'h3f;
	localparam logic [4:0] BLK_BAD_MAX = 5'h10;
	localparam logic [6:0] OFF_LAST = 7'h42;
	// Frame lock counts
	localparam logic [2:0] FRM_LOCK_LAST = 3'h3;
	localparam logic [2:0] FRM_BAD_LAST = 3'h3;
	// Control word codes and CRC constants
	localparam logic [63:0] SYNC_WORD = 64'h78f6_78f6_78f6_78f6;
	localparam logic [5:0] SCR_TYPE = 6'h0a;
	localparam logic [63:0] SKIP_WORD = 64'h1e1e_1e1e_1e1e_1e1e;
	localparam logic [31:0] DIAG_TYPE = 32'h6400_0000;
	localparam logic [31:0] CRC_POLY = 32'h1edc_6f41;
	localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
	// Default scrambler seed, arbitrary value
	localparam logic [57:0] SCR_SEED_RST = 58'h2ab_cdef_0123_4567;
	// Register map
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int ST_WLOCK = 0;
	localparam int ST_FLOCK = 1;
	localparam int ST_EV_LSB = 2;
	typedef enum logic [1:0] {
		B_SEARCH = 2'b01,
		B_LOCK = 2'b10
	} blk_state_type;
	typedef enum logic [2:0] {
		F_SEARCH = 3'b001,
		F_VERIFY = 3'b010,
		F_LOCK = 3'b100
	} frm_state_type;
	typedef struct packed {
		logic ctl;
		logic [63:0] data;
	} fab_word_type;
	typedef struct packed {
		logic ovf;
		logic crc;
		logic scr;
		logic sync;
	} pcs_ev_type;
	// Additive x58+x39+1 scrambler, 64 bits per word, msb first
	function automatic logic [121:0] scr_step(input logic [57:0] s,
		input logic [63:0] d);
		logic [57:0] l;
		logic [63:0] o;
		logic fb;
		l = s;
		o = d;
		for (int i = 63; i >= 0; i--)
		begin
			fb = l[57] ^ l[38];
			o[i] = d[i] ^ fb;
			l = {l[56:0], fb};
		end
		return {l, o};
	endfunction
	// CRC-32 over one 64-bit word, msb first
	function automatic logic [31:0] crc_step(input logic [31:0] c,
		input logic [63:0] d);
		logic [31:0] r;
		logic fb;
		r = c;
		for (int i = 63; i >= 0; i--)
		begin
			fb = r[31] ^ d[i];
			r = {r[30:0], 1'b0};
			if (fb)
				r = r ^ CRC_POLY;
		end
		return r;
	endfunction
endpackage

/* verilog/pcs_axil_regs.sv */
// AXI4-Lite register slave of the lane PCS
`timescale 1ns/1ps
module pcs_axil_regs import pcs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic word_lock,
	input wire logic frame_lock,
	input wire pcs_ev_type ev,
	output logic [12:0] mf_len
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [12:0] mf_len;
		logic [3:0] sticky;
	} regs_st_type;
	regs_st_type st_r;
	regs_st_type st_nxt;
	logic [3:0] clr;
	logic [12:0] len;
	// Address decode shared by read and write: 01 ctrl, 10 status
	function automatic logic [1:0] reg_sel(input logic [11:0] a);
		if (a == REG_CTRL)
			return 2'h1;
		else if (a == REG_STATUS)
			return 2'h2;
		else
			return 2'h0;
	endfunction
	// Bus handshakes, register writes and reads
	always_comb
	begin
		st_nxt = st_r;
		clr = 4'h0;
		len = st_r.mf_len;
		if (awvalid && st_r.awready)
		begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = awaddr;
		end
		if (wvalid && st_r.wready)
		begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = wdata;
			st_nxt.wstrb = wstrb;
		end
		// Write acts once both halves are in, whatever their order
		if (st_r.aw_got && st_r.w_got)
		begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			if (reg_sel(st_r.awaddr) == 2'h1)
			begin
				if (st_r.wstrb[0])
					len[7:0] = st_r.wdata[7:0];
				if (st_r.wstrb[1])
					len[12:8] = st_r.wdata[12:8];
				// Too short a metaframe is raised to the minimum
				st_nxt.mf_len = (len < MF_LEN_MIN) ? MF_LEN_MIN : len;
			end
			else if (reg_sel(st_r.awaddr) == 2'h2)
			begin
				if (st_r.wstrb[0])
					clr = st_r.wdata[ST_EV_LSB +: 4];
			end
			else
				st_nxt.bresp = RESP_SLVERR;
		end
		if (st_r.bvalid && bready)
			st_nxt.bvalid = 1'b0;
		// One write in flight: no new halves until response is gone
		st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid &&
			!(st_nxt.w_got && st_nxt.aw_got);
		st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
		// Sticky events: a new event beats a clear in the same cycle
		st_nxt.sticky = (st_r.sticky & ~clr) | ev;
		if (arvalid && st_r.arready)
		begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = 32'h0;
			if (reg_sel(araddr) == 2'h1)
				st_nxt.rdata[12:0] = st_r.mf_len;
			else if (reg_sel(araddr) == 2'h2)
			begin
				st_nxt.rdata[ST_WLOCK] = word_lock;
				st_nxt.rdata[ST_FLOCK] = frame_lock;
				st_nxt.rdata[ST_EV_LSB +: 4] = st_r.sticky;
			end
			else
				st_nxt.rresp = RESP_SLVERR;
		end
		else if (st_r.rvalid && rready)
		begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end
	end
	// State register, synchronous reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= '0;
			st_r.awready <= 1'b1;
			st_r.wready <= 1'b1;
			st_r.arready <= 1'b1;
			st_r.mf_len <= MF_LEN_RST;
		end
		else
			st_r <= st_nxt;
	end
	assign awready = st_r.awready;
	assign wready = st_r.wready;
	assign bresp = st_r.bresp;
	assign bvalid = st_r.bvalid;
	assign arready = st_r.arready;
	assign rdata = st_r.rdata;
	assign rresp = st_r.rresp;
	assign rvalid = st_r.rvalid;
	assign mf_len = st_r.mf_len;
endmodule // pcs_axil_regs

/* verif/pcs_lane_asserts.sv */
// Concurrent checks on the lane PCS top-level ports
`timescale 1ns/1ps
module pcs_lane_asserts import pcs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic tx_ready,
	input wire logic [66:0] tx_line,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic rx_word_lock,
	input wire logic rx_frame_lock,
	input wire logic rx_crc_err
);
	int rd_r;
	logic up_r;
	logic [6:0] nl_r;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Running disparity and unlocked time; the reset-time zero word is skipped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			up_r <= 1'b0;
			rd_r <= 0;
			nl_r <= 7'h00;
		end
		else
		begin
			up_r <= 1'b1;
			if (up_r)
				rd_r <= rd_r + 2 * $countones(tx_line) - 67;
			if (rx_word_lock)
				nl_r <= 7'h00;
			else if (nl_r != 7'h7f)
				nl_r <= nl_r + 7'h01;
		end
	end
	// Sync and state words leave unscrambled, possibly inverted
	sequence s_sync;
		tx_line[65:64] == HDR_CTRL &&
			tx_line[63:0] == (tx_line[66] ? ~SYNC_WORD : SYNC_WORD);
	endsequence
	sequence s_state;
		tx_line[65:64] == HDR_CTRL &&
			tx_line[63:58] == (tx_line[66] ? ~SCR_TYPE : SCR_TYPE);
	endsequence
	chk_disp_bound: assert property (rd_r <= 96 && rd_r >= -96)
		else $error("running disparity out of bound");
	chk_hdr_legal: assert property (up_r |->
		tx_line[65:64] == HDR_DATA || tx_line[65:64] == HDR_CTRL)
		else $error("illegal line header");
	chk_state_next: assert property (s_sync |=> s_state)
		else $error("state word missing after sync");
	chk_ctrl_slots: assert property (s_sync |->
		!tx_ready ##1 !tx_ready ##1 tx_ready)
		else $error("payload slot timing wrong");
	chk_lock_after: assert property ($rose(rx_word_lock) |-> nl_r >= 7'h40)
		else $error("word lock too early");
	chk_valid_lock: assert property (##1 rx_valid == $past(rx_word_lock))
		else $error("rx_valid not following word lock");
	chk_ready_lock: assert property (rx_ready ==
		(rx_word_lock && rx_frame_lock))
		else $error("ready not equal to both locks");
	chk_flock_word: assert property ($rose(rx_frame_lock) |-> rx_word_lock)
		else $error("frame lock without word lock");
	chk_crc_pulse: assert property (rx_crc_err |=> !rx_crc_err)
		else $error("crc error longer than one cycle");
	chk_wr_resp: assert property (awvalid && awready && wvalid && wready
		|-> ##2 bvalid)
		else $error("write response late");
	chk_rd_resp: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
endmodule // pcs_lane_asserts

/* verif/mac_model.sv */
// Fabric-side framing layer stand-in: counting source, checking sink
`timescale 1ns/1ps
module mac_model import pcs_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pause,
	input wire logic stall,
	input wire logic tx_ready,
	input wire fab_word_type rx_word,
	input wire logic rx_valid,
	input wire logic rx_ready,
	output fab_word_type tx_word,
	output logic tx_valid,
	output logic rx_accept,
	output int n_good,
	output int n_bad,
	output int n_sync
);
	logic [63:0] seq_r;
	logic [63:0] exp_r;
	logic run_r;
	assign tx_word = {1'b0, seq_r};
	assign rx_accept = !stall;
	// Offer held until taken; a pause only starts between words
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_valid <= 1'b0;
			seq_r <= 64'h0;
		end
		else if (!tx_valid || tx_ready)
		begin
			tx_valid <= !pause;
			if (tx_valid)
				seq_r <= seq_r + 64'h1;
		end
	end
	// Sink: deskew is ours, so sync words are counted, data sequenced
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			n_good <= 0;
			n_bad <= 0;
			n_sync <= 0;
			run_r <= 1'b0;
		end
		else if (rx_valid && rx_ready)
		begin
			if (rx_word.ctl && rx_word.data === SYNC_WORD)
				n_sync <= n_sync + 1;
			if (!rx_word.ctl)
			begin
				run_r <= 1'b1;
				exp_r <= (run_r ? exp_r : rx_word.data) + 64'h1;
				if (run_r && rx_word.data === exp_r)
					n_good <= n_good + 1;
				else if (run_r)
					n_bad <= n_bad + 1;
			end
		end
		else
			run_r <= 1'b0;
	end
endmodule // mac_model

/* verif/interlaken_lane_pcs_tb.sv */
// Self-checking bench for the lane PCS in line loopback
`timescale 1ns/1ps
module interlaken_lane_pcs_tb import pcs_pkg::*;;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, tx_valid, tx_ready, rx_valid;
	logic rx_accept, rx_ready, rx_word_lock, rx_frame_lock, rx_crc_err;
	logic pause, stall, flip_req, lost;
	// Set by the loopback alone, so one flip request hits one word only
	logic flip_done = 1'b0;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [66:0] tx_line, rx_line, hdr_mask;
	fab_word_type tx_word, rx_word;
	int n_good, n_bad, n_sync, base, error_cnt, n_compared;
	// Loopback counters start at zero and are written there alone
	int n_crc = 0;
	int cyc = 0;
	// Per-lane seed differs from the default
	interlaken_lane_pcs #(.SCR_SEED(58'h0f1_2e3d_4c5b_6a79)) u_dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .tx_word, .tx_valid,
		.tx_ready, .tx_line, .rx_line, .rx_word, .rx_valid, .rx_accept,
		.rx_ready, .rx_word_lock, .rx_frame_lock, .rx_crc_err);
	mac_model u_mac (.aclk, .aresetn, .pause, .stall, .tx_ready, .rx_word,
		.rx_valid, .rx_ready, .tx_word, .tx_valid, .rx_accept, .n_good,
		.n_bad, .n_sync);
	// Clock, 100 ns period
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// Loopback; a flip request hits payload bit 0 of one data word
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (rx_crc_err === 1'b1)
			n_crc <= n_crc + 1;
		if (flip_req && !flip_done && tx_line[65:64] == HDR_DATA)
		begin
			rx_line <= tx_line ^ 67'h1;
			flip_done <= 1'b1;
		end
		else
			rx_line <= tx_line ^ hdr_mask;
		if (cyc == 60000)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: timeout", $time);
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	// Write master: address and data offered together, each freed when taken
	task automatic wr_chk(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		do @(posedge aclk); while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er}, "write response");
	endtask
	// Read master; masked data compare plus response code
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
		input logic [31:0] m, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		chk(rdata & m, exp, "read data");
		chk({30'h0, rresp}, {30'h0, er}, "read response");
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 5000 && rx_ready !== 1'b1; i++)
			@(posedge aclk);
		chk({31'h0, rx_ready}, 32'h1, "no lock");
	endtask
	task automatic finish_test();
		$display("Compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{awvalid, wvalid, arvalid, pause, stall, flip_req} = 6'h0;
		{bready, rready, wstrb} = 6'h3f;
		{awaddr, araddr, wdata} = 56'h0;
		hdr_mask = 67'h0;
		{error_cnt, n_compared} = 64'h0;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(REG_CTRL, 32'h800, 32'hffffffff, RESP_OKAY);
		rd_chk(12'h008, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr_chk(12'h008, 32'h1, RESP_SLVERR);
		wr_chk(REG_CTRL, 32'h2, RESP_OKAY);
		rd_chk(REG_CTRL, 32'h5, 32'hffffffff, RESP_OKAY);
		wr_chk(REG_CTRL, 32'hffff, RESP_OKAY);
		rd_chk(REG_CTRL, 32'h1fff, 32'hffffffff, RESP_OKAY);
		wr_chk(REG_CTRL, 32'h8, RESP_OKAY);
		wait_ready();
		repeat (60) @(posedge aclk);
		wr_chk(REG_STATUS, 32'h3c, RESP_OKAY);
		rd_chk(REG_STATUS, 32'h3, 32'hffffffff, RESP_OKAY);
		chk(32'(n_good > 0), 32'h1, "no data through");
		chk(32'(n_sync > 0), 32'h1, "sync not forwarded");
		pause <= 1'b1;
		repeat (20) @(posedge aclk);
		pause <= 1'b0;
		repeat (40) @(posedge aclk);
		chk(n_bad, 32'h0, "data lost over idle");
		base = n_crc;
		flip_req <= 1'b1;
		repeat (40) @(posedge aclk);
		chk(n_crc, base + 1, "crc pulse");
		chk(n_bad, 32'h1, "single bit error");
		rd_chk(REG_STATUS, 32'h13, 32'hffffffff, RESP_OKAY);
		stall <= 1'b1;
		@(posedge aclk);
		stall <= 1'b0;
		wr_chk(REG_STATUS, 32'h10, RESP_OKAY);
		rd_chk(REG_STATUS, 32'h23, 32'hffffffff, RESP_OKAY);
		// 16 words with payload bit 0 flipped spoil three metaframes
		hdr_mask <= 67'h1;
		repeat (16) @(posedge aclk);
		hdr_mask <= 67'h0;
		lost = 1'b0;
		repeat (60)
		begin
			@(posedge aclk);
			lost = lost | (rx_frame_lock !== 1'b1);
		end
		chk({31'h0, lost}, 32'h0, "frame lock lost on 3 bad");
		rd_chk(REG_STATUS, 32'hf, 32'hf, RESP_OKAY);
		// Lasting corruption: fourth bad metaframe ends frame lock only
		hdr_mask <= 67'h1;
		for (int i = 0; i < 200 && rx_frame_lock !== 1'b0; i++)
			@(posedge aclk);
		chk({31'h0, rx_frame_lock}, 32'h0, "frame lock kept");
		chk({31'h0, rx_word_lock}, 32'h1, "word lock dropped");
		hdr_mask <= 67'h0;
		wait_ready();
		hdr_mask <= 67'h1 << 64;
		repeat (15) @(posedge aclk);
		hdr_mask <= 67'h0;
		lost = 1'b0;
		repeat (100)
		begin
			@(posedge aclk);
			lost = lost | (rx_word_lock !== 1'b1);
		end
		chk({31'h0, lost}, 32'h0, "lock lost on 15 bad");
		hdr_mask <= 67'h1 << 64;
		for (int i = 0; i < 200 && rx_word_lock !== 1'b0; i++)
			@(posedge aclk);
		chk({31'h0, rx_word_lock}, 32'h0, "lock kept");
		@(posedge aclk);
		chk({31'h0, rx_ready}, 32'h0, "ready kept");
		hdr_mask <= 67'h0;
		wait_ready();
		rd_chk(REG_STATUS, 32'h3, 32'h3, RESP_OKAY);
		finish_test();
	end
endmodule // interlaken_lane_pcs_tb
bind interlaken_lane_pcs pcs_lane_asserts u_chk (.aclk, .aresetn, .awvalid,
	.awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid,
	.tx_ready, .tx_line, .rx_valid, .rx_ready, .rx_word_lock,
	.rx_frame_lock, .rx_crc_err);
